// ==== lb_pkg.sv ====
// Constants, register numbers and carrier types of the dual lighting-bus
// register bank. Assumes a single 50 MHz clock and a synchronous reset.
package lb_pkg;

   // -------------------------------------------------------------------
   // Register numbers, as seen by the building management host
   // -------------------------------------------------------------------
   localparam logic [15:0] LB_BUS1_LEVEL_BASE = 16'h75D1;
   localparam logic [15:0] LB_BUS2_LEVEL_BASE = 16'h75E1;
   localparam logic [15:0] LB_BUS1_PCT = 16'h7611;
   localparam logic [15:0] LB_BUS2_PCT = 16'h7612;
   localparam logic [15:0] LB_BUS1_BLINK = 16'h9D46;
   localparam logic [15:0] LB_BUS2_BLINK = 16'h9D47;
   localparam logic [15:0] LB_BUS1_SP_BASE = 16'h9D4E;
   localparam logic [15:0] LB_BUS2_SP_BASE = 16'h9D5E;
   localparam logic [15:0] LB_BUS1_MIN_BASE = 16'h9D8E;
   localparam logic [15:0] LB_BUS2_MIN_BASE = 16'h9D9E;

   // -------------------------------------------------------------------
   // Sizes, limits and reset values
   // -------------------------------------------------------------------
   localparam logic [15:0] LB_BLOCK_LEN = 16'h0010;
   localparam logic [7:0] LB_LEVEL_MAX = 8'hFE;
   localparam logic [7:0] LB_MIN_MAX = 8'hFD;
   localparam logic [6:0] LB_PCT_MAX = 7'h64;
   localparam logic [7:0] LB_LEVEL_RST = 8'h00;
   localparam logic [15:0] LB_BLINK_RST = 16'h0000;

   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int LB_CLK_HZ = 50000000;
   localparam int LB_BLINK_HALF_MS = 500;
   localparam int LB_BLINK_HALF_CYC = LB_BLINK_HALF_MS * (LB_CLK_HZ / 1000);
   localparam int LB_BLINK_CNT_W = 25;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      LB_K_NONE, LB_K_LEVEL, LB_K_PCT, LB_K_BLINK, LB_K_SP, LB_K_MIN
   } lb_kind_t;

   typedef struct packed {
      lb_kind_t kind;
      logic bus;
      logic [3:0] idx;
   } lb_dec_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } lb_host_req_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [15:0] rdata;
   } lb_host_rsp_t;

   typedef struct packed {
      logic valid;
      logic bus;
      logic [3:0] idx;
      logic [7:0] level;
   } lb_upd_t;

   typedef struct packed {
      logic valid;
      logic bus;
      logic [3:0] idx;
      logic [7:0] level;
      logic off;
   } lb_demand_t;

endpackage : lb_pkg

// ==== lb_level_mem.sv ====
// Small memory holding the 32 reported ballast levels, two buses of 16.
// Assumes one clock; read data come out of a register one cycle later.
`timescale 1ns/1ps
`default_nettype none
module lb_level_mem (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Write port
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Read port
   input wire logic [4:0] rd_addr,
   output logic [7:0] rd_data
);
   import lb_pkg::*;

   typedef struct packed {
      logic [31:0][7:0] mem;
      logic [7:0] rdata;
   } lb_mem_state_t;

   lb_mem_state_t mem_ff;
   lb_mem_state_t nxt_mem;

   // Read before write: a read of the entry being written sees old data.
   always_comb begin
      nxt_mem = mem_ff;
      nxt_mem.rdata = mem_ff.mem[rd_addr];
      if (wr_en) begin
         nxt_mem.mem[wr_addr] = wr_data;
      end
   end

   // Cleared at reset so that an unreported ballast reads as level zero.
   always_ff @(posedge clock) begin
      if (rst) begin
         mem_ff <= '0;
      end else begin
         mem_ff <= nxt_mem;
      end
   end

   assign rd_data = mem_ff.rdata;

endmodule : lb_level_mem
`default_nettype wire

// ==== lb_regbank.sv ====
// Register bank for two lighting-bus interfaces of 16 ballasts each.
// Assumes the bus engine reports levels, progress and commissioning state,
// and consumes the demand stream; host requests are synchronous to clock.
// Every host request is answered two edges after the edge that takes it.
// The demand stream refreshes one ballast per cycle, all 32 in a round when both buses are commissioned.
`timescale 1ns/1ps
`default_nettype none
module lb_regbank #(
   parameter int BLINK_HALF_CYC = lb_pkg::LB_BLINK_HALF_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Host register port
   input wire lb_pkg::lb_host_req_t host_req,
   output lb_pkg::lb_host_rsp_t host_rsp,
   // Bus engine status
   input wire logic [1:0] bus_commissioned,
   input wire logic [6:0] bus1_discovery_in,
   input wire logic [6:0] bus2_discovery_in,
   input wire lb_pkg::lb_upd_t level_upd,
   // Wall switch dimming
   input wire logic switch1_dimming_disable,
   input wire logic switch2_dimming_disable,
   input wire lb_pkg::lb_upd_t switch_req,
   // Demand stream toward the bus engine
   output lb_pkg::lb_demand_t demand
);
   import lb_pkg::*;

   // -------------------------------------------------------------------
   // Decoding helpers
   // -------------------------------------------------------------------

   // True when the register number falls in a 16-entry block at base.
   // The subtraction wraps, so numbers below the base fall outside too.
   function automatic logic lb_in_blk(input logic [15:0] a,
                                      input logic [15:0] base);
      logic [15:0] diff;
      diff = a - base;
      return (diff < LB_BLOCK_LEN);
   endfunction : lb_in_blk

   // Maps a register number to its kind, bus and ballast index.
   function automatic lb_dec_t lb_decode(input logic [15:0] a);
      lb_dec_t d;
      logic [15:0] diff;
      d = '0;
      d.kind = LB_K_NONE;
      diff = '0;
      if (lb_in_blk(a, LB_BUS1_LEVEL_BASE)) begin
         d.kind = LB_K_LEVEL;
         diff = a - LB_BUS1_LEVEL_BASE;
      end else if (lb_in_blk(a, LB_BUS2_LEVEL_BASE)) begin
         d.kind = LB_K_LEVEL;
         d.bus = 1'b1;
         diff = a - LB_BUS2_LEVEL_BASE;
      end else if (a == LB_BUS1_PCT || a == LB_BUS2_PCT) begin
         d.kind = LB_K_PCT;
         d.bus = (a == LB_BUS2_PCT);
      end else if (a == LB_BUS1_BLINK || a == LB_BUS2_BLINK) begin
         d.kind = LB_K_BLINK;
         d.bus = (a == LB_BUS2_BLINK);
      end else if (lb_in_blk(a, LB_BUS1_SP_BASE)) begin
         d.kind = LB_K_SP;
         diff = a - LB_BUS1_SP_BASE;
      end else if (lb_in_blk(a, LB_BUS2_SP_BASE)) begin
         d.kind = LB_K_SP;
         d.bus = 1'b1;
         diff = a - LB_BUS2_SP_BASE;
      end else if (lb_in_blk(a, LB_BUS1_MIN_BASE)) begin
         d.kind = LB_K_MIN;
         diff = a - LB_BUS1_MIN_BASE;
      end else if (lb_in_blk(a, LB_BUS2_MIN_BASE)) begin
         d.kind = LB_K_MIN;
         d.bus = 1'b1;
         diff = a - LB_BUS2_MIN_BASE;
      end
      // Single registers leave the index at zero; only blocks use it.
      d.idx = diff[3:0];
      return d;
   endfunction : lb_decode

   // Saturates a 16-bit value at an 8-bit ceiling.
   // Host data wider than a level is clipped, never wrapped.
   function automatic logic [7:0] lb_sat(input logic [15:0] v,
                                         input logic [7:0] top);
      logic [7:0] r;
      r = (v > {8'h00, top}) ? top : v[7:0];
      return r;
   endfunction : lb_sat

   // Raises a level to the floor when it sits below it.
   function automatic logic [7:0] lb_floor(input logic [7:0] v,
                                           input logic [7:0] low);
      logic [7:0] r;
      r = (v < low) ? low : v;
      return r;
   endfunction : lb_floor

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      // Per-ballast host registers, indexed by bus then ballast.
      logic [1:0][15:0][7:0] sp;
      logic [1:0][15:0][7:0] mn;
      logic [1:0][15:0] blink;
      // Shared blink time base.
      logic [LB_BLINK_CNT_W-1:0] blink_cnt;
      logic blink_phase;
      // Position of the demand refresh scan.
      logic [4:0] scan;
      // First answer stage of the host port.
      logic p_valid;
      logic p_err;
      logic p_mem;
      logic p_gate;
      logic [15:0] p_data;
      // Registered outputs.
      lb_host_rsp_t rsp;
      lb_demand_t dem;
   } lb_state_t;

   lb_state_t state_ff;
   lb_state_t nxt_state;

   // Last count of a blink half period; the parameter lets a short
   // simulation shorten the period so that it sees both phases.
   localparam logic [LB_BLINK_CNT_W-1:0] BLINK_LAST =
      LB_BLINK_CNT_W'(BLINK_HALF_CYC - 1);

   // Combinational helpers; none of them holds state.
   logic [7:0] mem_rdata;
   logic [1:0] dim_disable;
   logic [1:0][6:0] pct_in;
   lb_dec_t req_dec;
   logic [4:0] mem_rd_addr;

   // -------------------------------------------------------------------
   // Per-bus input grouping
   // -------------------------------------------------------------------

   // Gathers per-bus inputs into vectors indexed by bus number.
   // The request is decoded once here and shared by write and read paths.
   assign dim_disable = {switch2_dimming_disable, switch1_dimming_disable};
   assign pct_in[0] = bus1_discovery_in;
   assign pct_in[1] = bus2_discovery_in;
   assign req_dec = lb_decode(host_req.addr);
   assign mem_rd_addr = {req_dec.bus, req_dec.idx};

   // -------------------------------------------------------------------
   // Actual level store
   // -------------------------------------------------------------------

   // Engine reports land here; the host port cannot write it.
   // Levels are saturated on the way in, so a faulty report above the
   // top level can never be read back by the host.
   lb_level_mem u_level_mem (
      .clock(clock),
      .rst(rst),
      .wr_en(level_upd.valid),
      .wr_addr({level_upd.bus, level_upd.idx}),
      .wr_data(lb_sat({8'h00, level_upd.level}, LB_LEVEL_MAX)),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rdata)
   );

   // -------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------

   // Switch requests are applied before host writes, so a host write to
   // the same setpoint in the same cycle wins: the host is the authority.
   // Every field of the next state starts as a copy of the present one.
   always_comb begin
      logic b;
      logic [3:0] i;
      logic [7:0] lvl;
      logic [15:0] rd;
      b = 1'b0;
      i = '0;
      lvl = '0;
      rd = '0;
      nxt_state = state_ff;

      // Wall switch level change, bounded below by the minimum.
      // A disabled or uncommissioned bus drops the request silently.
      if (switch_req.valid && bus_commissioned[switch_req.bus]
          && !dim_disable[switch_req.bus]) begin
         b = switch_req.bus;
         i = switch_req.idx;
         lvl = lb_sat({8'h00, switch_req.level}, LB_LEVEL_MAX);
         nxt_state.sp[b][i] = lb_floor(lvl, state_ff.mn[b][i]);
      end

      // Host writes; read-only kinds fall through untouched.
      // An uncommissioned bus keeps its registers, so such a write is lost.
      if (host_req.valid && host_req.write
          && bus_commissioned[req_dec.bus]) begin
         b = req_dec.bus;
         i = req_dec.idx;
         unique case (req_dec.kind)
            LB_K_BLINK: begin
               nxt_state.blink[b] = host_req.wdata;
            end
            LB_K_SP: begin
               lvl = lb_sat(host_req.wdata, LB_LEVEL_MAX);
               nxt_state.sp[b][i] = lb_floor(lvl, state_ff.mn[b][i]);
            end
            LB_K_MIN: begin
               nxt_state.mn[b][i] = lb_sat(host_req.wdata, LB_MIN_MAX);
            end
            LB_K_NONE, LB_K_LEVEL, LB_K_PCT: begin
               nxt_state.p_err = state_ff.p_err;
            end
         endcase
      end

      // First answer stage: capture everything but the memory data.
      // The level memory read starts on the same edge, so both halves
      // of the answer meet one cycle later.
      nxt_state.p_valid = host_req.valid;
      nxt_state.p_err = (req_dec.kind == LB_K_NONE);
      nxt_state.p_mem = (req_dec.kind == LB_K_LEVEL);
      nxt_state.p_gate = bus_commissioned[req_dec.bus];
      b = req_dec.bus;
      i = req_dec.idx;
      unique case (req_dec.kind)
         LB_K_PCT: begin
            rd = (pct_in[b] > LB_PCT_MAX) ? {9'h000, LB_PCT_MAX}
                                          : {9'h000, pct_in[b]};
         end
         LB_K_BLINK: begin
            rd = state_ff.blink[b];
         end
         LB_K_SP: begin
            rd = {8'h00, state_ff.sp[b][i]};
         end
         LB_K_MIN: begin
            rd = {8'h00, state_ff.mn[b][i]};
         end
         LB_K_NONE, LB_K_LEVEL: begin
            rd = '0;
         end
      endcase
      // Progress is readable before commissioning; the rest reads zero.
      // Progress has to be visible while the discovery is still running.
      if (!bus_commissioned[b] && req_dec.kind != LB_K_PCT) begin
         rd = '0;
      end
      nxt_state.p_data = rd;

      // Second answer stage: merge the level memory output.
      // Level reads of an uncommissioned bus are gated here, not earlier.
      nxt_state.rsp.valid = state_ff.p_valid;
      nxt_state.rsp.err = state_ff.p_valid && state_ff.p_err;
      nxt_state.rsp.rdata = '0;
      if (state_ff.p_valid) begin
         if (state_ff.p_mem) begin
            nxt_state.rsp.rdata = state_ff.p_gate ? {8'h00, mem_rdata}
                                                  : 16'h0000;
         end else begin
            nxt_state.rsp.rdata = state_ff.p_data;
         end
      end

      // Shared blink time base keeps every blinking ballast in step.
      // The counter runs free, so a newly set blink bit may start in
      // either phase; its first half period can be short.
      if (state_ff.blink_cnt >= BLINK_LAST) begin
         nxt_state.blink_cnt = '0;
         nxt_state.blink_phase = !state_ff.blink_phase;
      end else begin
         nxt_state.blink_cnt = state_ff.blink_cnt + 1'b1;
      end

      // Demand refresh walks all 32 ballasts, one per cycle.
      // A change reaches the engine within one round of 32 cycles, far
      // shorter than any lamp can follow.
      nxt_state.scan = state_ff.scan + 1'b1;
      b = state_ff.scan[4];
      i = state_ff.scan[3:0];
      lvl = lb_floor(state_ff.sp[b][i], state_ff.mn[b][i]);
      nxt_state.dem.valid = bus_commissioned[b];
      nxt_state.dem.bus = b;
      nxt_state.dem.idx = i;
      nxt_state.dem.level = lvl;
      // Bus one treats zero as an off command; bus two as its minimum.
      nxt_state.dem.off = !b && (lvl == LB_LEVEL_RST);
      if (state_ff.blink[b][i] && state_ff.blink_phase) begin
         nxt_state.dem.level = LB_LEVEL_RST;
         nxt_state.dem.off = 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------

   // All setpoints, minimums and blink masks clear at reset.
   // The blink counter and scan restart too, so the first round is known.
   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------

   // Both outputs are fields of the state register.
   // No logic sits between the flip-flops and the pins.
   assign host_rsp = state_ff.rsp;
   assign demand = state_ff.dem;

endmodule : lb_regbank
`default_nettype wire

// ==== lb_regbank_sva.sv ====
// Port checker for the dual lighting-bus register bank.
// Assumes it is bound onto lb_regbank with one clock and sync reset.
`timescale 1ns/1ps
`default_nettype none
module lb_regbank_sva
   import lb_pkg::*;
#(
   parameter int BLINK_HALF_CYC = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Host port
   input wire lb_pkg::lb_host_req_t host_req,
   input wire lb_pkg::lb_host_rsp_t host_rsp,
   // Engine side
   input wire logic [1:0] bus_commissioned,
   input wire lb_pkg::lb_demand_t demand
);
   // -------------------------------------------------------------
   // Sequences and properties
   // -------------------------------------------------------------
   // One domain, so the clock and the reset are stated once.
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // A host read of either progress register.
   sequence s_pct_read;
      host_req.valid && !host_req.write &&
      (host_req.addr == LB_BUS1_PCT || host_req.addr == LB_BUS2_PCT);
   endsequence

   // A host write aimed at a read-only level register.
   sequence s_ro_write;
      host_req.valid && host_req.write &&
      host_req.addr == LB_BUS1_LEVEL_BASE;
   endsequence

   a_rsp_latency: assert property (
      host_req.valid |-> ##2 host_rsp.valid)
      else $error("answer did not come two cycles after request");
   a_rsp_caused: assert property (
      host_rsp.valid |-> $past(host_req.valid, 2))
      else $error("answer without a request");
   a_pct_bound: assert property (
      s_pct_read |-> ##2 host_rsp.valid && host_rsp.rdata <= 16'h0064)
      else $error("progress read above one hundred");
   a_ro_write_ok: assert property (
      s_ro_write |-> ##2 host_rsp.valid && !host_rsp.err)
      else $error("write to read-only register flagged");
   a_level_cap: assert property (
      demand.valid |-> demand.level <= LB_LEVEL_MAX)
      else $error("demand level above 254");
   a_bus1_off: assert property (
      demand.valid && !demand.bus |-> demand.off == (demand.level == 8'h00))
      else $error("bus one off flag does not follow level zero");
   a_off_zero: assert property (
      demand.valid && demand.off |-> demand.level == 8'h00)
      else $error("off demand carries a level");
   a_demand_gate: assert property (
      demand.valid && demand.bus |-> $past(bus_commissioned[1]))
      else $error("demand on a bus not commissioned");
   a_scan_step: assert property (
      demand.valid && $past(demand.valid) |->
      {demand.bus, demand.idx} == 5'($past({demand.bus, demand.idx}) + 5'h01))
      else $error("demand scan skipped an entry");
endmodule : lb_regbank_sva

bind lb_regbank lb_regbank_sva #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_sva (
   .clock(clock), .rst(rst), .host_req(host_req), .host_rsp(host_rsp),
   .bus_commissioned(bus_commissioned), .demand(demand));
`default_nettype wire

// ==== lb_host_model.sv ====
// Building management host model: issues one register request at a time.
// Assumes the caller enters its task just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module lb_host_model
   import lb_pkg::*;
(
   // Clock
   input wire logic clock,
   // Register port
   output lb_pkg::lb_host_req_t host_req,
   input wire lb_pkg::lb_host_rsp_t host_rsp
);
   initial host_req = '0;

   // Pulse the request for one edge, then wait a bounded time for the
   // answer; the bound turns a lost answer into a visible zero result.
   task automatic xfer(input logic wr, input logic [15:0] a,
         input logic [15:0] wd, output lb_host_rsp_t r);
      int n;
      host_req = '{valid: 1'b1, write: wr, addr: a, wdata: wd};
      @(posedge clock);
      #1 host_req = '0;
      r = '0;
      for (n = 0; n < 8 && r.valid !== 1'b1; n++) begin
         @(posedge clock);
         r = host_rsp;
      end
      #1;
   endtask : xfer
endmodule : lb_host_model
`default_nettype wire

// ==== tb_dual_lighting_ballast_register_bank.sv ====
// Self-checking bench for the dual lighting-bus register bank.
// Assumes lb_host_model drives the host port; blink half period shortened.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_lighting_ballast_register_bank;
   import lb_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   lb_host_req_t host_req;
   lb_host_rsp_t host_rsp;
   logic [1:0] bus_commissioned = 2'b01;
   logic [6:0] bus1_discovery_in = 7'h2A;
   logic [6:0] bus2_discovery_in = 7'h7F;
   lb_upd_t level_upd = '0;
   logic switch1_dimming_disable = 1'b0;
   logic switch2_dimming_disable = 1'b1;
   lb_upd_t switch_req = '0;
   lb_demand_t demand;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #10 clock = ~clock;

   // Half period of 48 so samples 32 cycles apart see both phases.
   lb_regbank #(.BLINK_HALF_CYC(48)) dut (.clock(clock), .rst(rst),
      .host_req(host_req), .host_rsp(host_rsp),
      .bus_commissioned(bus_commissioned),
      .bus1_discovery_in(bus1_discovery_in),
      .bus2_discovery_in(bus2_discovery_in), .level_upd(level_upd),
      .switch1_dimming_disable(switch1_dimming_disable),
      .switch2_dimming_disable(switch2_dimming_disable),
      .switch_req(switch_req), .demand(demand));
   lb_host_model host (.clock(clock), .host_req(host_req),
      .host_rsp(host_rsp));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      lb_host_rsp_t r;
      host.xfer(1'b0, a, 16'h0000, r);
      check({15'h0000, r.valid}, 16'h0001);
      check(r.rdata, exp);
   endtask : rd

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      lb_host_rsp_t r;
      host.xfer(1'b1, a, d, r);
      check({14'h0000, r.valid, r.err}, 16'h0002);
   endtask : wr

   // One-cycle pulse on the switch port or the level report port.
   task automatic upd(input logic sw, input logic b, input logic [3:0] i,
         input logic [7:0] l);
      if (sw) switch_req = '{1'b1, b, i, l};
      else level_upd = '{1'b1, b, i, l};
      @(posedge clock);
      #1 switch_req = '0;
      level_upd = '0;
   endtask : upd

   // Catch the next demand entry of one ballast, bounded by 40 cycles, a little over one 32-cycle scan.
   task automatic entry(input logic b, input logic [3:0] i,
         output lb_demand_t d);
      int n;
      d = '0;
      for (n = 0; n < 40 && d.valid !== 1'b1; n++) begin
         @(posedge clock);
         if (demand.valid === 1'b1 && demand.bus === b && demand.idx === i)
            d = demand;
      end
      #1;
   endtask : entry

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   // A hang is cut short at 5000 cycles, well after the expected run of a few hundred.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         $display("MISMATCH t=%0t run did not finish", $time);
         conclude();
      end
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      lb_host_rsp_t r;
      lb_demand_t d;
      int k;
      int offs;
      repeat (8) @(posedge clock);
      #1 rst = 1'b0;
      rd(LB_BUS1_BLINK, 16'h0000);
      rd(LB_BUS1_SP_BASE + 16'h000F, 16'h0000);
      rd(LB_BUS1_MIN_BASE, 16'h0000);
      rd(LB_BUS1_PCT, 16'h002A);
      rd(LB_BUS2_PCT, 16'h0064);
      wr(LB_BUS1_PCT, 16'h0005);
      rd(LB_BUS1_PCT, 16'h002A);
      upd(1'b0, 1'b0, 4'h0, 8'h80);
      upd(1'b0, 1'b0, 4'hF, 8'hFF);
      wr(LB_BUS1_LEVEL_BASE, 16'h0011);
      rd(LB_BUS1_LEVEL_BASE, 16'h0080);
      rd(LB_BUS1_LEVEL_BASE + 16'h000F, 16'h00FE);
      // Bus two refuses per-ballast access until commissioned.
      upd(1'b0, 1'b1, 4'h0, 8'h33);
      wr(LB_BUS2_SP_BASE, 16'h0044);
      rd(LB_BUS2_SP_BASE, 16'h0000);
      rd(LB_BUS2_LEVEL_BASE, 16'h0000);
      bus_commissioned = 2'b11;
      rd(LB_BUS2_LEVEL_BASE, 16'h0033);
      rd(LB_BUS2_SP_BASE, 16'h0000);
      wr(LB_BUS1_SP_BASE + 16'h0003, 16'h0123);
      rd(LB_BUS1_SP_BASE + 16'h0003, 16'h00FE);
      wr(LB_BUS1_MIN_BASE + 16'h0003, 16'h00FF);
      rd(LB_BUS1_MIN_BASE + 16'h0003, 16'h00FD);
      wr(LB_BUS2_MIN_BASE + 16'h0002, 16'h0030);
      wr(LB_BUS2_SP_BASE + 16'h0002, 16'h0010);
      rd(LB_BUS2_SP_BASE + 16'h0002, 16'h0030);
      // Switch requests: ignored while disabled, floored at the minimum.
      upd(1'b1, 1'b1, 4'h2, 8'h40);
      rd(LB_BUS2_SP_BASE + 16'h0002, 16'h0030);
      switch2_dimming_disable = 1'b0;
      upd(1'b1, 1'b1, 4'h2, 8'h40);
      rd(LB_BUS2_SP_BASE + 16'h0002, 16'h0040);
      upd(1'b1, 1'b1, 4'h2, 8'h05);
      rd(LB_BUS2_SP_BASE + 16'h0002, 16'h0030);
      entry(1'b0, 4'h1, d);
      check({7'h00, d.off, d.level}, 16'h0100);
      entry(1'b1, 4'h5, d);
      check({7'h00, d.off, d.level}, 16'h0000);
      entry(1'b0, 4'h3, d);
      check({7'h00, d.off, d.level}, 16'h00FE);
      // Ballasts 3 and 15 blink together; ballast 3 is sampled, then steadies when its bit clears.
      wr(LB_BUS1_BLINK, 16'h8008);
      rd(LB_BUS1_BLINK, 16'h8008);
      offs = 0;
      for (k = 0; k < 8; k++) begin
         entry(1'b0, 4'h3, d);
         if (d.off === 1'b1 && d.level === 8'h00) offs++;
         else check({7'h00, d.off, d.level}, 16'h00FE);
      end
      check(16'(offs > 0 && offs < 8), 16'h0001);
      wr(LB_BUS1_BLINK, 16'h8000);
      for (k = 0; k < 4; k++) begin
         entry(1'b0, 4'h3, d);
         check({7'h00, d.off, d.level}, 16'h00FE);
      end
      host.xfer(1'b0, 16'h0000, 16'h0000, r);
      check({r.rdata[14:0], r.err}, 16'h0001);
      conclude();
   end
endmodule : tb_dual_lighting_ballast_register_bank
`default_nettype wire
